// ---- common/fsrd_pkg.sv ----
package fsrd_pkg;

	// ==========================================================
	// configuration space word offsets
	localparam logic [11:0] CFG_MAKER_ID   = 12'h000;
	localparam logic [11:0] CFG_PART_ID    = 12'h001;
	localparam logic [11:0] CFG_BLOCK_LOCK = 12'h002;
	localparam logic [11:0] CFG_GLOBAL     = 12'h003;
	localparam logic [11:0] CFG_MODE_COPY  = 12'h004;
	localparam logic [11:0] CFG_HW_DISABLE = 12'h005;

	// ==========================================================
	// status word bit positions
	localparam int SR_DEV_LEVEL  = 0;
	localparam int SR_BANK_LO    = 1;
	localparam int SR_BANK_HI    = 2;
	localparam int SR_PROT_VIOL  = 3;
	localparam int SR_PROG_FAIL  = 4;
	localparam int SR_ERASE_FAIL = 5;
	localparam int SR_READY      = 7;

	// ==========================================================
	// reset values
	localparam logic       HW_DISABLE_RST = 1'b0;
	localparam logic [15:0] MODE_COPY_RST = 16'h0000;

	// ==========================================================
	// read source selection
	typedef enum logic [1:0] {
		FSRD_RD_ARRAY,
		FSRD_RD_STATUS,
		FSRD_RD_CONFIG
	} fsrd_rdmode_e;

	// events reported by the write engine, one-cycle pulses
	typedef struct packed {
		logic       start;
		logic       device_level;
		logic [1:0] bank;
		logic       done;
		logic       erase_fail;
		logic       unprotect_fail;
		logic       prog_fail;
		logic       protect_viol;
	} fsrd_engine_ev_s;

	// host read request
	typedef struct packed {
		logic        valid;
		fsrd_rdmode_e mode;
		logic [1:0]  bank;
		logic [11:0] addr;
	} fsrd_read_req_s;

endpackage : fsrd_pkg

// ---- verilog/fsrd_status_cfg.sv ----
// Chosen here: strobed register access.
`timescale 1ns/1ps
module fsrd_status_cfg #(
	parameter int          NUM_BLOCKS = 64,
	parameter logic        X32        = 1'b0,
	// arbitrary identity values, not those of any part
	parameter logic [15:0] MAKER_ID   = 16'h00A5,
	parameter logic [15:0] PART_X16   = 16'h0011,
	parameter logic [15:0] PART_X32   = 16'h0012
) (
	// clock and reset
	input  wire logic                      mclk,
	input  wire logic                      srst,
	// write engine events and commands
	input  wire fsrd_pkg::fsrd_engine_ev_s engine_ev,
	input  wire logic                      clear_status,
	input  wire logic                      mode_load,
	input  wire logic [15:0]               mode_data,
	input  wire logic                      lock_write,
	input  wire logic [$clog2(NUM_BLOCKS)-1:0] lock_block,
	input  wire logic                      lock_value,
	input  wire logic                      global_write,
	input  wire logic                      global_value,
	input  wire logic                      hw_disable_set,
	// host read port
	input  wire fsrd_pkg::fsrd_read_req_s  rd_req,
	input  wire logic [15:0]               array_word,
	input  wire logic [15:0]               held_row_word,
	output logic                           rd_valid,
	output logic [31:0]                    rd_data,
	output logic                           engine_ready_bit
);
	import fsrd_pkg::*;

	localparam int BW = $clog2(NUM_BLOCKS);

	// ==========================================================
	// write engine tracking
	logic       busy;
	logic       device_level_op_flag;
	logic [1:0] active_bank;
	logic       erase_fail_flag;
	logic       prog_fail_flag;
	logic       protect_viol_flag;

	always_ff @(posedge mclk) begin
		if (srst)
			busy <= 1'b0;
		else if (engine_ev.start)
			busy <= 1'b1;
		else if (engine_ev.done)
			busy <= 1'b0;
	end

	// operation level and bank latched at start
	always_ff @(posedge mclk) begin
		if (srst) begin
			device_level_op_flag <= 1'b0;
			active_bank          <= 2'h0;
		end else if (engine_ev.start) begin
			device_level_op_flag <= engine_ev.device_level;
			active_bank          <= engine_ev.bank;
		end
	end

	// erase failure sets; set wins over clear
	// cleared only by clear command or reset
	always_ff @(posedge mclk) begin
		if (srst)
			erase_fail_flag <= 1'b0;
		// unprotect failure sets the same flag
		else if (engine_ev.erase_fail || engine_ev.unprotect_fail)
			erase_fail_flag <= 1'b1;
		else if (clear_status)
			erase_fail_flag <= 1'b0;
	end

	always_ff @(posedge mclk) begin
		if (srst)
			prog_fail_flag <= 1'b0;
		else if (engine_ev.prog_fail)
			prog_fail_flag <= 1'b1;
		else if (clear_status)
			prog_fail_flag <= 1'b0;
	end

	// violation cleared only by clear or reset
	always_ff @(posedge mclk) begin
		if (srst)
			protect_viol_flag <= 1'b0;
		else if (engine_ev.protect_viol)
			protect_viol_flag <= 1'b1;
		else if (clear_status)
			protect_viol_flag <= 1'b0;
	end

	assign engine_ready_bit = ~busy;

	// ==========================================================
	// status word assembly
	logic [15:0] status_word;

	always_comb begin
		status_word = 16'h0000;
		status_word[SR_READY]      = ~busy;
		status_word[SR_ERASE_FAIL] = erase_fail_flag;
		status_word[SR_PROG_FAIL]  = prog_fail_flag;
		status_word[SR_PROT_VIOL]  = protect_viol_flag;
		// bank code straight from bank number
		// bank bits forced low when ready
		status_word[SR_BANK_HI]    = busy & active_bank[1];
		status_word[SR_BANK_LO]    = busy & active_bank[0];
		// level flag forced low when ready
		status_word[SR_DEV_LEVEL]  = busy & device_level_op_flag;
	end

	// ==========================================================
	// configuration storage
	logic [NUM_BLOCKS-1:0] block_lock;
	logic                  global_lock;
	logic [15:0]           mode_copy;
	logic                  hw_disable;

	// lock bits are nonvolatile in silicon; here they start unlocked
	always_ff @(posedge mclk) begin
		if (srst)
			block_lock <= '0;
		else if (lock_write)
			block_lock[lock_block] <= lock_value;
	end

	always_ff @(posedge mclk) begin
		if (srst)
			global_lock <= 1'b0;
		else if (global_write)
			global_lock <= global_value;
	end

	always_ff @(posedge mclk) begin
		if (srst)
			mode_copy <= MODE_COPY_RST;
		else if (mode_load)
			mode_copy <= mode_data;
	end

	// factory value zero, only ever set
	always_ff @(posedge mclk) begin
		if (srst)
			hw_disable <= HW_DISABLE_RST;
		else if (hw_disable_set)
			hw_disable <= 1'b1;
	end

	// ==========================================================
	// configuration decode
	logic [15:0]   cfg_word;
	logic [BW-1:0] blk_index;
	logic [9:0]    blk_digit;

	// block number is the low BW bits of bank plus upper address digits; bank drops out unless BW exceeds 10
	always_comb begin
		blk_digit = {2'h0, rd_req.addr[11:4]};
		blk_index = BW'({rd_req.bank, blk_digit});
	end

	always_comb begin
		// reserved and don't-care bits return zero
		cfg_word = 16'h0000;
		case (rd_req.addr[3:0])
			CFG_MAKER_ID[3:0]:   cfg_word = MAKER_ID;
			CFG_PART_ID[3:0]:    cfg_word = X32 ? PART_X32 : PART_X16;
			CFG_BLOCK_LOCK[3:0]: cfg_word[0] = block_lock[blk_index];
			CFG_GLOBAL[3:0]:     cfg_word[0] = global_lock;
			CFG_MODE_COPY[3:0]:  cfg_word = mode_copy;
			CFG_HW_DISABLE[3:0]: cfg_word[0] = hw_disable;
			default:             cfg_word = 16'h0000;
		endcase
	end

	// ==========================================================
	// read data path
	logic [15:0] next_word;

	always_comb begin
		case (rd_req.mode)
			FSRD_RD_STATUS: next_word = status_word;
			FSRD_RD_CONFIG: next_word = cfg_word;
			// busy bank of a bank-level operation shows row held before the sequence
			FSRD_RD_ARRAY:  next_word = (busy && !device_level_op_flag &&
			                            rd_req.bank == active_bank) ?
			                            held_row_word : array_word;
			default:        next_word = 16'h0000;
		endcase
	end

	// reads never stalled by engine activity
	always_ff @(posedge mclk) begin
		if (srst)
			rd_valid <= 1'b0;
		else
			rd_valid <= rd_req.valid;
	end

	// x32 upper half copies lower half
	always_ff @(posedge mclk) begin
		if (srst)
			rd_data <= 32'h0000_0000;
		else if (rd_req.valid)
			rd_data <= X32 ? {next_word, next_word} : {16'h0000, next_word};
	end

	// ==========================================================
	// assertions
	sequence s_fail_event;
		engine_ev.erase_fail || engine_ev.unprotect_fail;
	endsequence

	sequence s_flag_held;
		erase_fail_flag ##1 (erase_fail_flag || $past(clear_status));
	endsequence

	a_erase_fail_set: assert property (@(posedge mclk) disable iff (srst)
		s_fail_event |=> s_flag_held)
		else $error("erase fail flag not set after failure");

	a_unprot_sets: assert property (@(posedge mclk) disable iff (srst)
		engine_ev.unprotect_fail |=> erase_fail_flag)
		else $error("unprotect failure did not set flag");

	a_erase_clear_only: assert property (@(posedge mclk) disable iff (srst)
		$fell(erase_fail_flag) |-> $past(clear_status))
		else $error("erase fail flag cleared without clear command");

	a_viol_clear_only: assert property (@(posedge mclk) disable iff (srst)
		$fell(protect_viol_flag) |-> $past(clear_status))
		else $error("violation flag cleared without clear command");

	a_bank_code: assert property (@(posedge mclk) disable iff (srst)
		engine_ev.start ##1 busy |-> status_word[2:1] == $past(engine_ev.bank))
		else $error("bank code mismatch");

	a_bank_ready_zero: assert property (@(posedge mclk) disable iff (srst)
		status_word[SR_READY] |-> status_word[2:1] == 2'h0)
		else $error("bank bits nonzero while ready");

	a_level_ready_zero: assert property (@(posedge mclk) disable iff (srst)
		status_word[SR_READY] |-> !status_word[SR_DEV_LEVEL])
		else $error("device-level flag set while ready");

	a_ready_busy: assert property (@(posedge mclk) disable iff (srst)
		engine_ev.start |=> !engine_ready_bit)
		else $error("ready still high after start");

	a_read_latency: assert property (@(posedge mclk) disable iff (srst)
		rd_req.valid |=> rd_valid)
		else $error("read not answered next cycle");

	a_mirror_x32: assert property (@(posedge mclk) disable iff (srst)
		rd_valid && X32 |-> rd_data[31:16] == rd_data[15:0])
		else $error("upper half not a copy of lower");

	a_reserved_zero: assert property (@(posedge mclk) disable iff (srst)
		status_word[15:8] == 8'h00 && !status_word[6])
		else $error("reserved status bit nonzero");

	sequence s_cfg_read;
		rd_req.valid && rd_req.mode == FSRD_RD_CONFIG;
	endsequence

	sequence s_array_read;
		rd_req.valid && rd_req.mode == FSRD_RD_ARRAY;
	endsequence

	a_viol_set: assert property (@(posedge mclk) disable iff (srst)
		engine_ev.protect_viol |=> protect_viol_flag)
		else $error("violation flag not set after violation");

	a_prog_fail_set: assert property (@(posedge mclk) disable iff (srst)
		engine_ev.prog_fail |=> prog_fail_flag)
		else $error("program fail flag not set after failure");

	a_erase_kept: assert property (@(posedge mclk) disable iff (srst)
		erase_fail_flag && !clear_status |=> erase_fail_flag)
		else $error("erase fail flag lost without clear command");

	a_viol_kept: assert property (@(posedge mclk) disable iff (srst)
		protect_viol_flag && !clear_status |=> protect_viol_flag)
		else $error("violation flag lost without clear command");

	a_clear_drops: assert property (@(posedge mclk) disable iff (srst)
		clear_status && !engine_ev.erase_fail && !engine_ev.unprotect_fail |=> !erase_fail_flag)
		else $error("clear command did not clear erase fail flag");

	a_viol_clear: assert property (@(posedge mclk) disable iff (srst)
		clear_status && !engine_ev.protect_viol |=> !protect_viol_flag)
		else $error("clear command did not clear violation flag");

	a_level_code: assert property (@(posedge mclk) disable iff (srst)
		engine_ev.start |=> status_word[SR_DEV_LEVEL] == $past(engine_ev.device_level))
		else $error("device-level flag does not match operation");

	a_ready_idle: assert property (@(posedge mclk) disable iff (srst)
		engine_ev.done && !engine_ev.start |=> engine_ready_bit)
		else $error("ready not raised after engine done");

	a_status_read: assert property (@(posedge mclk) disable iff (srst)
		rd_req.valid && rd_req.mode == FSRD_RD_STATUS |=> rd_data[15:0] == $past(status_word))
		else $error("status read returned wrong word");

	a_maker_read: assert property (@(posedge mclk) disable iff (srst)
		s_cfg_read ##0 rd_req.addr[3:0] == CFG_MAKER_ID[3:0] |=> rd_data[15:0] == MAKER_ID)
		else $error("maker identity read wrong");

	a_part_read: assert property (@(posedge mclk) disable iff (srst)
		s_cfg_read ##0 rd_req.addr[3:0] == CFG_PART_ID[3:0] |=>
		rd_data[15:0] == (X32 ? PART_X32 : PART_X16))
		else $error("part identity read wrong");

	a_block_read: assert property (@(posedge mclk) disable iff (srst)
		s_cfg_read ##0 rd_req.addr[3:0] == CFG_BLOCK_LOCK[3:0] |=>
		rd_data[15:0] == {15'h0, $past(block_lock[blk_index])})
		else $error("block lock read wrong");

	a_global_read: assert property (@(posedge mclk) disable iff (srst)
		s_cfg_read ##0 rd_req.addr[3:0] == CFG_GLOBAL[3:0] |=>
		rd_data[15:0] == {15'h0, $past(global_lock)})
		else $error("device lock read wrong");

	a_mode_read: assert property (@(posedge mclk) disable iff (srst)
		s_cfg_read ##0 rd_req.addr[3:0] == CFG_MODE_COPY[3:0] |=>
		rd_data[15:0] == $past(mode_copy))
		else $error("mode copy read wrong");

	a_hw_read: assert property (@(posedge mclk) disable iff (srst)
		s_cfg_read ##0 rd_req.addr[3:0] == CFG_HW_DISABLE[3:0] |=>
		rd_data[15:0] == {15'h0, $past(hw_disable)})
		else $error("load disable read wrong");

	a_hw_sticky: assert property (@(posedge mclk) disable iff (srst)
		hw_disable |=> hw_disable)
		else $error("load disable bit cleared without reset");

	a_busy_row: assert property (@(posedge mclk) disable iff (srst)
		s_array_read ##0 (busy && !device_level_op_flag && rd_req.bank == active_bank) |=>
		rd_data[15:0] == $past(held_row_word))
		else $error("busy bank did not return held row");

	a_other_row: assert property (@(posedge mclk) disable iff (srst)
		s_array_read ##0 !(busy && !device_level_op_flag && rd_req.bank == active_bank) |=>
		rd_data[15:0] == $past(array_word))
		else $error("free bank did not return array data");

	a_valid_pulse: assert property (@(posedge mclk) disable iff (srst)
		!rd_req.valid |=> !rd_valid)
		else $error("read valid without request");

	a_data_hold: assert property (@(posedge mclk) disable iff (srst)
		!rd_req.valid |=> $stable(rd_data))
		else $error("read data changed without request");

endmodule : fsrd_status_cfg

// ---- dv/fsrd_host_model.sv ----
`timescale 1ns/1ps
module fsrd_host_model (
	// clock
	input  wire logic                mclk,
	// commands and reads toward the device
	output logic                     clear_status,
	output fsrd_pkg::fsrd_read_req_s rd_req,
	input  wire logic                rd_valid,
	input  wire logic [31:0]         rd_data
);
	import fsrd_pkg::*;

	initial begin
		clear_status = 1'b0;
		rd_req       = '0;
	end

	// ==========================================================
	// flags cleared first
	// error flags are only meaningful if cleared before each write
	task automatic clear();
		@(posedge mclk);
		clear_status <= 1'b1;
		@(posedge mclk);
		clear_status <= 1'b0;
	endtask : clear

	// ==========================================================
	// bank and digit
	// answer is sampled in the one cycle where it stands
	task automatic read(input fsrd_rdmode_e m, input logic [1:0] b, input logic [11:0] a,
		output logic [31:0] d, output logic ok);
		@(posedge mclk);
		rd_req <= '{valid: 1'b1, mode: m, bank: b, addr: a};
		@(posedge mclk);
		rd_req <= '{valid: 1'b0, mode: m, bank: ~b, addr: ~a};
		#1;
		ok = rd_valid;
		d  = rd_data;
	endtask : read
endmodule : fsrd_host_model

// ---- dv/fsrd_bench.sv ----
`timescale 1ns/1ps
module flash_status_and_config_readout_bench;
	import fsrd_pkg::*;
	// arbitrary identity values
	localparam logic [15:0] MAKER = 16'h005A;
	localparam logic [15:0] PART  = 16'h0033;

	logic            mclk, srst, clear_status, mode_load, lock_write, lock_value;
	logic            global_write, global_value, hw_disable_set, rd_valid, engine_ready_bit;
	logic [15:0]     mode_data, array_word, held_row_word;
	logic [5:0]      lock_block;
	logic [31:0]     rd_data;
	fsrd_engine_ev_s engine_ev;
	fsrd_read_req_s  rd_req;
	int              failures, checked;

	fsrd_status_cfg #(.NUM_BLOCKS(64), .X32(1'b1), .MAKER_ID(MAKER), .PART_X32(PART)) dut_u (
		.mclk(mclk), .srst(srst), .engine_ev(engine_ev), .clear_status(clear_status),
		.mode_load(mode_load), .mode_data(mode_data), .lock_write(lock_write),
		.lock_block(lock_block), .lock_value(lock_value), .global_write(global_write),
		.global_value(global_value), .hw_disable_set(hw_disable_set), .rd_req(rd_req),
		.array_word(array_word), .held_row_word(held_row_word), .rd_valid(rd_valid),
		.rd_data(rd_data), .engine_ready_bit(engine_ready_bit));
	fsrd_host_model host_u (.mclk(mclk), .clear_status(clear_status), .rd_req(rd_req),
		.rd_valid(rd_valid), .rd_data(rd_data));

	// ==========================================================
	// helpers
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic rd(input fsrd_rdmode_e m, input logic [1:0] b, input logic [11:0] a,
		input logic [15:0] e, input string n);
		logic [31:0] d;
		logic        ok;
		host_u.read(m, b, a, d, ok);
		chk({n, " valid"}, 32'h1, {31'h0, ok});
		chk(n, {e, e}, d);
	endtask : rd

	// bits: start, device_level, bank, done, erase, unprotect, prog, violation
	task automatic ev(input logic [8:0] e);
		@(posedge mclk);
		engine_ev <= e;
		@(posedge mclk);
		engine_ev <= '0;
	endtask : ev

	// ==========================================================
	// scenarios
	task automatic t_banks();
		for (int b = 0; b < 4; b++) begin
			host_u.clear();
			ev({2'b10, 2'(b), 5'h00});
			rd(FSRD_RD_STATUS, 0, 0, 16'(b << 1), "bank busy");
			chk("ready busy", 32'h0, {31'h0, engine_ready_bit});
			ev(9'h010);
			rd(FSRD_RD_STATUS, 0, 0, 16'h0080, "bank idle");
		end
		host_u.clear();
		ev(9'h180);
		rd(FSRD_RD_STATUS, 0, 0, 16'h0001, "device busy");
		ev(9'h010);
		rd(FSRD_RD_STATUS, 0, 0, 16'h0080, "device idle");
	endtask : t_banks

	task automatic t_errors();
		host_u.clear();
		ev(9'h120);
		ev(9'h008);
		rd(FSRD_RD_STATUS, 0, 0, 16'h0022, "erase fail busy");
		ev(9'h010);
		rd(FSRD_RD_STATUS, 0, 0, 16'h00A0, "erase fail");
		rd(FSRD_RD_STATUS, 0, 0, 16'h00A0, "erase sticky idle");
		host_u.clear();
		ev(9'h004);
		rd(FSRD_RD_STATUS, 0, 0, 16'h00A0, "unprotect fail");
		ev(9'h003);
		rd(FSRD_RD_STATUS, 0, 0, 16'h00B8, "prog and violation");
		host_u.clear();
		rd(FSRD_RD_STATUS, 0, 0, 16'h0080, "cleared");
	endtask : t_errors

	task automatic t_config();
		rd(FSRD_RD_CONFIG, 0, CFG_HW_DISABLE, 16'h0000, "hw disable reset");
		@(posedge mclk);
		{mode_load, global_write, hw_disable_set, lock_write} <= 4'hF;
		@(posedge mclk);
		{mode_load, global_write, hw_disable_set, lock_write} <= 4'h0;
		rd(FSRD_RD_CONFIG, 0, CFG_MAKER_ID, MAKER, "maker id");
		rd(FSRD_RD_CONFIG, 0, CFG_PART_ID, PART, "part id");
		rd(FSRD_RD_CONFIG, 0, 12'h052, 16'h0001, "block 5 lock");
		rd(FSRD_RD_CONFIG, 0, 12'h062, 16'h0000, "block 6 lock");
		rd(FSRD_RD_CONFIG, 0, CFG_GLOBAL, 16'h0001, "device lock");
		rd(FSRD_RD_CONFIG, 0, CFG_MODE_COPY, 16'h1234, "mode copy");
		rd(FSRD_RD_CONFIG, 0, CFG_HW_DISABLE, 16'h0001, "hw disable set");
	endtask : t_config

	task automatic t_array();
		host_u.clear();
		ev(9'h140);
		rd(FSRD_RD_ARRAY, 2, 12'h010, 16'h5555, "busy bank row");
		rd(FSRD_RD_ARRAY, 1, 12'h010, 16'hAAAA, "other bank");
		ev(9'h010);
		rd(FSRD_RD_ARRAY, 2, 12'h010, 16'hAAAA, "idle bank");
	endtask : t_array

	// ==========================================================
	// run control
	task automatic results();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	initial begin
		repeat (5000) @(posedge mclk);
		failures++;
		results();
	end

	initial begin
		{srst, failures, checked} = {1'b1, 64'h0};
		{mode_load, global_write, hw_disable_set, lock_write, lock_value} = 5'h01;
		{global_value, lock_block, mode_data, engine_ev} = {1'b1, 6'h05, 16'h1234, 9'h000};
		{array_word, held_row_word} = {16'hAAAA, 16'h5555};
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		chk("ready reset", 32'h1, {31'h0, engine_ready_bit});
		rd(FSRD_RD_STATUS, 0, 0, 16'h0080, "status reset");
		t_banks();
		t_errors();
		t_config();
		t_array();
		results();
	end
endmodule : flash_status_and_config_readout_bench
